// ===== vcm_drive_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "vcm_defs.svh"
module vcm_drive_ctrl
    import vcm_pkg::*;
#(
    parameter int unsigned SHDN_CYCLES =
        (`SHDN_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // serial register port
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // analog monitors
    input  wire logic       overtempIn,
    input  wire logic       coilShortIn,
    input  wire logic       coilOpenIn,
    input  wire logic       senseAbove,
    // output stage
    output logic [9:0]      dacCode,
    output logic            stageEnable,
    output logic            pwmSelect,
    output logic            highSideOn,
    output logic            lowSideOn
);
    // ****************************************
    // reset release and input synchronisers
    // ****************************************
    logic [1:0] rstSync_r;               // reset release chain
    logic       rstN;                    // synchronised reset
    logic [5:0] in1_r, in2_r;            // two-stage pin sync
    logic       sclS, sdaS, aboveS;      // synchronised levels
    fault_type  flt;                     // synchronised faults
    logic       faultAny;

    // reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_r <= 2'b00;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstN = rstSync_r[1];

    // pin synchronisers
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            in1_r <= 6'h03;
            in2_r <= 6'h03;
        end else begin
            in1_r <= {overtempIn, coilShortIn, coilOpenIn, senseAbove, sdaIn, sclIn};
            in2_r <= in1_r;
        end
    end
    assign sclS     = in2_r[0];
    assign sdaS     = in2_r[1];
    assign aboveS   = in2_r[2];
    assign flt      = in2_r[5:3];
    assign faultAny = |flt;

    // ****************************************
    // register port
    // ****************************************
    regWr_type  wr;                      // write strobe from port
    logic [7:0] rdAddr, rdData;          // read pointer and data
    logic       stopSeen;                // transfer ended
    mode_type   mode_r, mode_nxt;        // operating mode

    i2c_reg_slave u_port (
        .clk      (clk),
        .rstN     (rstN),
        .enable   (mode_r != SHUTDOWN),
        .sclS     (sclS),
        .sdaS     (sdaS),
        .sdaOe    (sdaOe),
        .wr       (wr),
        .rdAddr   (rdAddr),
        .rdData   (rdData),
        .stopSeen (stopSeen)
    );
    assign sdaOut = 1'b0;                // open drain: only pulls low

    // ****************************************
    // shutdown detection
    // ****************************************
    logic [16:0] low_r, low_nxt;         // clock-line low time
    logic        shdnReq;                // low long enough

    // count low time, saturate at the limit
    always_comb begin
        low_nxt = 17'h00000;
        if (!sclS && low_r != 17'(SHDN_CYCLES - 1)) begin
            low_nxt = low_r + 17'h00001;
        end else if (!sclS) begin
            low_nxt = low_r;
        end
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            low_r <= 17'h00000;
        end else begin
            low_r <= low_nxt;
        end
    end
    assign shdnReq = !sclS && low_r == 17'(SHDN_CYCLES - 1);

    // ****************************************
    // registers
    // ****************************************
    logic [1:0] fsel_r, fsel_nxt;        // switching frequency select
    logic       pwm_r, pwm_nxt;          // pwm drive chosen
    logic [9:0] stage_r, stage_nxt;      // staged setpoint bytes
    logic       pend_r, pend_nxt;        // staged value waiting
    logic [9:0] setp_r, setp_nxt;        // committed setpoint
    logic [7:0] res_r, res_nxt;          // resonance tuning
    logic [2:0] stat_r, stat_nxt;        // sticky fault flags
    logic       srst, loadDef, wrHit;

    assign srst    = wr.valid && wr.addr == `REG_CTRL && wr.data[`CTRL_SRST_BIT];
    assign loadDef = mode_r == SHUTDOWN || srst;
    assign wrHit   = wr.valid && !loadDef;

    // register writes, defaults and fault clearing
    always_comb begin
        fsel_nxt  = fsel_r;
        pwm_nxt   = pwm_r;
        stage_nxt = stage_r;
        pend_nxt  = pend_r;
        setp_nxt  = setp_r;
        res_nxt   = res_r;
        // write one clears a flag; a fault seen in active wins
        stat_nxt  = stat_r;
        if (wrHit && wr.addr == `REG_STATUS) begin
            stat_nxt = stat_r & ~wr.data[2:0];
        end
        if (mode_r == ACTIVE) begin
            stat_nxt = stat_nxt | flt;
        end
        if (loadDef) begin
            // defaults on wake and soft reset
            fsel_nxt  = `CTRL_RST;
            pwm_nxt   = `MODE_RST;
            stage_nxt = `CUR_RST;
            pend_nxt  = 1'b0;
            setp_nxt  = `CUR_RST;
            res_nxt   = `RES_RST;
        end else begin
            if (wrHit) begin
                case (wr.addr)
                    `REG_CTRL:   fsel_nxt = wr.data[`CTRL_FSEL_LSB +: 2];
                    `REG_MODE:   pwm_nxt = wr.data[`MODE_PWM_BIT];
                    `REG_RES:    res_nxt = wr.data;
                    `REG_CUR_HI: begin
                        stage_nxt[9:8] = wr.data[1:0];
                        pend_nxt       = 1'b1;
                    end
                    `REG_CUR_LO: begin
                        stage_nxt[7:0] = wr.data;
                        pend_nxt       = 1'b1;
                    end
                    default: ;
                endcase
            end
            if (stopSeen && pend_r) begin
                // both bytes land together
                setp_nxt = stage_r;
                pend_nxt = 1'b0;
            end
            if (mode_r == ACTIVE && faultAny) begin
                // fault drops the setpoint, other register writes still land
                stage_nxt = `CUR_RST;
                pend_nxt  = 1'b0;
                setp_nxt  = `CUR_RST;
            end
        end
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            fsel_r  <= `CTRL_RST;
            pwm_r   <= `MODE_RST;
            stage_r <= `CUR_RST;
            pend_r  <= 1'b0;
            setp_r  <= `CUR_RST;
            res_r   <= `RES_RST;
            stat_r  <= 3'h0;
        end else begin
            fsel_r  <= fsel_nxt;
            pwm_r   <= pwm_nxt;
            stage_r <= stage_nxt;
            pend_r  <= pend_nxt;
            setp_r  <= setp_nxt;
            res_r   <= res_nxt;
            stat_r  <= stat_nxt;
        end
    end

    // read data mux, unmapped reads give zero
    always_comb begin
        case (rdAddr)
            `REG_CTRL:   rdData = {5'h00, fsel_r, 1'b0};
            `REG_MODE:   rdData = {7'h00, pwm_r};
            `REG_CUR_HI: rdData = {6'h00, setp_r[9:8]};
            `REG_CUR_LO: rdData = setp_r[7:0];
            `REG_STATUS: rdData = {3'h0, mode_r == ACTIVE, mode_r == STANDBY, stat_r};
            `REG_RES:    rdData = res_r;
            default:     rdData = 8'h00;
        endcase
    end

    // ****************************************
    // mode sequencing
    // ****************************************
    always_comb begin
        mode_nxt = mode_r;
        if (shdnReq) begin
            mode_nxt = SHUTDOWN;
        end else begin
            case (mode_r)
                SHUTDOWN: if (sclS) mode_nxt = STANDBY;
                STANDBY:  if (setp_r != `CUR_RST) mode_nxt = ACTIVE;
                ACTIVE: begin
                    if (faultAny || srst || setp_r == `CUR_RST) begin
                        mode_nxt = STANDBY;
                    end
                end
                default: mode_nxt = SHUTDOWN;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            mode_r <= SHUTDOWN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // ****************************************
    // ringing compensation ramp
    // ****************************************
    logic [9:0]  dac_r, dac_nxt;         // DAC code
    logic [15:0] rcnt_r, rcnt_nxt;       // step spacing counter
    logic [15:0] gap;                    // cycles between steps
    logic        tick;

    // lower resonance gives slower ramp
    assign gap  = `RAMP_BASE + (16'(8'hFF - res_r) * `RAMP_SCALE);
    assign tick = rcnt_r == 16'h0000;
    always_comb begin
        dac_nxt  = dac_r;
        rcnt_nxt = tick ? gap : rcnt_r - 16'h0001;
        if (mode_r == SHUTDOWN) begin
            dac_nxt = `CUR_RST;
        end else if (tick && dac_r < setp_r) begin
            dac_nxt = dac_r + 10'h001;
        end else if (tick && dac_r > setp_r) begin
            dac_nxt = dac_r - 10'h001;
        end
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            dac_r  <= `CUR_RST;
            rcnt_r <= 16'h0000;
        end else begin
            dac_r  <= dac_nxt;
            rcnt_r <= rcnt_nxt;
        end
    end
    assign dacCode = dac_r;

    // ****************************************
    // output stage
    // ****************************************
    logic [7:0] pcnt_r, pcnt_nxt;        // switching period counter
    logic [7:0] per;                     // period in cycles
    logic       chg_r, chg_nxt;          // charge phase
    logic       hs_r, hs_nxt, ls_r, ls_nxt, en_r, en_nxt;

    always_comb begin
        case (fsel_r)
            2'h0:    per = 8'(`CLK_FREQ_KHZ / `FSW0_KHZ);
            2'h1:    per = 8'(`CLK_FREQ_KHZ / `FSW1_KHZ);
            2'h2:    per = 8'(`CLK_FREQ_KHZ / `FSW2_KHZ);
            default: per = 8'(`CLK_FREQ_KHZ / `FSW3_KHZ);
        endcase
    end

    // charge until sensed current passes DAC, then freewheel
    always_comb begin
        pcnt_nxt = (pcnt_r >= per - 8'h01) ? 8'h00 : pcnt_r + 8'h01;
        chg_nxt  = chg_r;
        if (pcnt_r == 8'h00) begin
            chg_nxt = ~aboveS;
        end else if (aboveS) begin
            chg_nxt = 1'b0;
        end
        en_nxt = mode_r == ACTIVE;
        hs_nxt = en_nxt && (pwm_r ? chg_r : 1'b1);
        ls_nxt = en_nxt && pwm_r && !chg_r;
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pcnt_r <= 8'h00;
            chg_r  <= 1'b0;
            en_r   <= 1'b0;
            hs_r   <= 1'b0;
            ls_r   <= 1'b0;
        end else begin
            pcnt_r <= pcnt_nxt;
            chg_r  <= chg_nxt;
            en_r   <= en_nxt;
            hs_r   <= hs_nxt;
            ls_r   <= ls_nxt;
        end
    end
    assign stageEnable = en_r;
    assign pwmSelect   = pwm_r;
    assign highSideOn  = hs_r;
    assign lowSideOn   = ls_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstN);

    sequence wakeEdge_s; mode_r == SHUTDOWN && sclS && !shdnReq; endsequence
    sequence stbyDef_s; mode_r == STANDBY && res_r == `RES_RST && setp_r == `CUR_RST; endsequence

    shdn_entry_a: assert property (shdnReq |=> mode_r == SHUTDOWN)
        else $error("no shutdown after long clock-line low");
    wake_std_a: assert property (wakeEdge_s |=> stbyDef_s)
        else $error("wake did not reach standby with defaults");
    go_active_a: assert property (mode_r == STANDBY && setp_r != 10'h000 && !shdnReq
        |=> mode_r == ACTIVE)
        else $error("nonzero setpoint did not activate");
    ramp_step_a: assert property (mode_r != SHUTDOWN && dac_r != setp_r && tick
        |=> (dac_r != $past(dac_r) && !tick) ##1 !tick)
        else $error("ramp did not step once");
    res_write_a: assert property (wr.valid && wr.addr == `REG_RES && !loadDef
        |=> res_r == $past(wr.data))
        else $error("resonance write lost");
    stage_off_a: assert property (mode_r != ACTIVE |=> !en_r && !hs_r && !ls_r)
        else $error("stage driven outside active");
    lin_drive_a: assert property (mode_r == ACTIVE && !pwm_r |=> hs_r && !ls_r)
        else $error("linear drive not static high side");
    pwm_phase_a: assert property (!(hs_r && ls_r) && (pcnt_r < per || $changed(fsel_r)))
        else $error("switching period or phase overlap");
    fault_drop_a: assert property (mode_r == ACTIVE && faultAny && !shdnReq
        |=> mode_r == STANDBY && setp_r == 10'h000)
        else $error("fault did not drop to standby");
    soft_rst_a: assert property (mode_r == ACTIVE && srst && !shdnReq
        |=> mode_r == STANDBY && res_r == `RES_RST && !pwm_r)
        else $error("soft reset incomplete");
    atomic_cur_a: assert property ($changed(setp_r)
        |-> $past(stopSeen) || $past(loadDef) || $past(faultAny))
        else $error("setpoint changed mid transfer");
endmodule
`default_nettype wire

// ===== vcm_defs.svh
`ifndef VCM_DEFS_SVH
`define VCM_DEFS_SVH
// clock
`define CLK_PERIOD_NS   10
`define CLK_FREQ_KHZ    100000
// clock-line low time that requests shutdown
`define SHDN_TIME_US    500
// register offsets
`define REG_CTRL        8'h02
`define REG_MODE        8'h03
`define REG_CUR_HI      8'h04
`define REG_CUR_LO      8'h05
`define REG_STATUS      8'h06
`define REG_RES         8'h07
// field positions
`define CTRL_SRST_BIT   0
`define CTRL_FSEL_LSB   1
`define MODE_PWM_BIT    0
// reset values
`define CTRL_RST        2'h0
`define MODE_RST        1'h0
`define RES_RST         8'h80
`define CUR_RST         10'h000
// switching frequencies
`define FSW0_KHZ        500
`define FSW1_KHZ        1000
`define FSW2_KHZ        2000
`define FSW3_KHZ        4000
// ramp step spacing: base plus scale per code below full scale
`define RAMP_BASE       16'h0010
`define RAMP_SCALE      16'h0004
// i2c
`define ACK_BYTES       2'h2
`endif

// ===== vcm_pkg.sv
package vcm_pkg;
    // operating modes
    typedef enum logic [1:0] {SHUTDOWN, STANDBY, ACTIVE} mode_type;
    // one register write from the serial port
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } regWr_type;
    // protection inputs
    typedef struct packed {
        logic overtempFault;
        logic coilShortFault;
        logic coilOpenFault;
    } fault_type;
endpackage

// ===== i2c_reg_slave.sv
`timescale 1ns/1ns
`default_nettype none
`include "vcm_defs.svh"
module i2c_reg_slave
    import vcm_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary bus address
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstN,
    // port enable, off in shutdown
    input  wire logic       enable,
    // synchronised pins
    input  wire logic       sclS,
    input  wire logic       sdaS,
    output logic            sdaOe,
    // register side
    output regWr_type       wr,
    output logic [7:0]      rdAddr,
    input  wire logic [7:0] rdData,
    output logic            stopSeen
);
    // ****************************************
    // serial engine
    // ****************************************
    typedef enum {IDLE, RXBYTE, ACKBIT, TXBYTE, RXACK} slv_type;
    slv_type    st_r, st_nxt;        // engine state
    logic       sclP_r, sdaP_r;      // previous pin levels
    logic [7:0] sh_r, sh_nxt;        // shift register
    logic [3:0] bit_r, bit_nxt;      // bit counter
    logic [1:0] idx_r, idx_nxt;      // byte index in transfer
    logic       rd_r, rd_nxt;        // read transfer
    logic [7:0] ptr_r, ptr_nxt;      // register pointer
    logic       oe_r, oe_nxt;        // sda pull low
    regWr_type  wr_r, wr_nxt;        // write strobe
    logic       stop_r, stop_nxt;    // stop pulse
    logic       rise, fall, start, stop;

    assign rise  = sclS & ~sclP_r;
    assign fall  = ~sclS & sclP_r;
    assign start = sclS & sclP_r & sdaP_r & ~sdaS;
    assign stop  = sclS & sclP_r & ~sdaP_r & sdaS;

    // next state of the engine
    always_comb begin
        st_nxt   = st_r;
        sh_nxt   = sh_r;
        bit_nxt  = bit_r;
        idx_nxt  = idx_r;
        rd_nxt   = rd_r;
        ptr_nxt  = ptr_r;
        oe_nxt   = oe_r;
        wr_nxt   = '0;
        stop_nxt = 1'b0;
        if (!enable) begin
            st_nxt = IDLE;
            oe_nxt = 1'b0;
        end else if (start) begin
            // start or repeated start
            st_nxt  = RXBYTE;
            bit_nxt = 4'h0;
            idx_nxt = 2'h0;
            oe_nxt  = 1'b0;
        end else if (stop) begin
            st_nxt   = IDLE;
            oe_nxt   = 1'b0;
            stop_nxt = 1'b1;
        end else begin
            case (st_r)
                RXBYTE: begin
                    if (rise) begin
                        sh_nxt  = {sh_r[6:0], sdaS};
                        bit_nxt = bit_r + 4'h1;
                    end else if (fall && bit_r == 4'h8) begin
                        st_nxt = ACKBIT;
                        oe_nxt = 1'b1;
                        if (idx_r == 2'h0) begin
                            // address byte: acknowledge only our own
                            rd_nxt = sh_r[0];
                            if (sh_r[7:1] != DEV_ADDR) begin
                                st_nxt = IDLE;
                                oe_nxt = 1'b0;
                            end
                        end else if (idx_r == 2'h1) begin
                            ptr_nxt = sh_r;
                        end else begin
                            wr_nxt  = '{valid: 1'b1, addr: ptr_r, data: sh_r};
                            ptr_nxt = ptr_r + 8'h01;
                        end
                        if (idx_r != `ACK_BYTES) begin
                            idx_nxt = idx_r + 2'h1;
                        end
                    end
                end
                ACKBIT: begin
                    if (fall) begin
                        bit_nxt = 4'h0;
                        if (rd_r) begin
                            st_nxt  = TXBYTE;
                            sh_nxt  = rdData;
                            oe_nxt  = ~rdData[7];
                            ptr_nxt = ptr_r + 8'h01;
                        end else begin
                            st_nxt = RXBYTE;
                            oe_nxt = 1'b0;
                        end
                    end
                end
                TXBYTE: begin
                    if (fall) begin
                        if (bit_r == 4'h7) begin
                            st_nxt = RXACK;
                            oe_nxt = 1'b0;
                        end else begin
                            sh_nxt  = {sh_r[6:0], 1'b0};
                            oe_nxt  = ~sh_r[6];
                            bit_nxt = bit_r + 4'h1;
                        end
                    end
                end
                RXACK: begin
                    // master acknowledge asks for another byte
                    if (rise && sdaS) begin
                        st_nxt = IDLE;
                    end else if (fall) begin
                        st_nxt  = TXBYTE;
                        bit_nxt = 4'h0;
                        sh_nxt  = rdData;
                        oe_nxt  = ~rdData[7];
                        ptr_nxt = ptr_r + 8'h01;
                    end
                end
                default: st_nxt = IDLE;
            endcase
        end
    end

    // engine registers
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            st_r   <= IDLE;
            sclP_r <= 1'b1;
            sdaP_r <= 1'b1;
            sh_r   <= 8'h00;
            bit_r  <= 4'h0;
            idx_r  <= 2'h0;
            rd_r   <= 1'b0;
            ptr_r  <= 8'h00;
            oe_r   <= 1'b0;
            wr_r   <= '0;
            stop_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            sclP_r <= sclS;
            sdaP_r <= sdaS;
            sh_r   <= sh_nxt;
            bit_r  <= bit_nxt;
            idx_r  <= idx_nxt;
            rd_r   <= rd_nxt;
            ptr_r  <= ptr_nxt;
            oe_r   <= oe_nxt;
            wr_r   <= wr_nxt;
            stop_r <= stop_nxt;
        end
    end

    // standard slave signalling, up to fast-mode rate
    assign sdaOe    = oe_r;
    assign wr       = wr_r;
    assign rdAddr   = ptr_r;
    assign stopSeen = stop_r;
endmodule
`default_nettype wire

// ===== i2c_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
    // clock
    input  wire logic clk,
    // bus pins
    input  wire logic sdaOe,
    output logic      scl,
    output wire logic sda
);
    logic hostLow; // host pulls data low
    logic lastSda; // data level seen while the clock is high
    int   nack;    // bytes left unacknowledged
    assign sda = ~(hostLow | sdaOe); // pull-up level when released
    initial begin
        scl = 1'b1;
        hostLow = 1'b0;
    end
    // quarter bit, keeps the bus near 397 kHz
    task automatic q();
        repeat (63) @(posedge clk);
    endtask
    // one bit, data changes only while the clock is low
    task automatic bitOut(input logic b);
        hostLow <= ~b;
        q();
        scl <= 1'b1;
        q();
        lastSda <= sda;
        q();
        scl <= 1'b0;
        q();
    endtask
    // byte then a released acknowledge slot
    task automatic sendByte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) bitOut(b[i]);
        bitOut(1'b1);
        if (lastSda !== 1'b0) nack++;
    endtask
    // write n data bytes from the top of d, starting at register a
    task automatic xfer(input logic [7:0] a, input logic [31:0] d, input int n);
        hostLow <= 1'b1;
        q();
        scl <= 1'b0;
        q();
        sendByte(8'h54);
        sendByte(a);
        for (int i = 0; i < n; i++) sendByte(d[31-8*i -: 8]);
        hostLow <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        hostLow <= 1'b0;
        q();
    endtask
    // clock line held low to request shutdown
    task automatic holdLow(input int n);
        scl <= 1'b0;
        repeat (n) @(posedge clk);
        scl <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== test_vcm_drive_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module test_vcm_drive_ctrl;
    import vcm_pkg::*;
    logic        clk, rst_n, sclIn, sdaOut, sdaOe, senseAbove, watchRamp;
    logic        overtempIn, coilShortIn, coilOpenIn, loopSense;
    logic        stageEnable, pwmSelect, highSideOn, lowSideOn;
    wire logic   sdaIn;
    logic [9:0]  dacCode, sp, prevDac;
    logic [11:0] expQ[$];
    int          n_mismatch, total_checks;
    event        probe;
    time         t0;
    vcm_drive_ctrl #(.SHDN_CYCLES(400)) u_dut (.clk(clk), .rst_n(rst_n), .sclIn(sclIn),
        .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .overtempIn(overtempIn),
        .coilShortIn(coilShortIn), .coilOpenIn(coilOpenIn), .senseAbove(senseAbove),
        .dacCode(dacCode), .stageEnable(stageEnable), .pwmSelect(pwmSelect),
        .highSideOn(highSideOn), .lowSideOn(lowSideOn));
    i2c_host_model u_host (.clk(clk), .sdaOe(sdaOe), .scl(sclIn), .sda(sdaIn));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // note {stage, pwm, dac} expected once outputs have settled
    task automatic note(input logic [11:0] e);
        #2;
        expQ.push_back(e);
        -> probe;
    endtask
    task automatic waitDac(input logic [9:0] v);
        for (int k = 0; k < 6000 && dacCode !== v; k++) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask
    task automatic setSp(input logic [9:0] v);
        u_host.xfer(8'h04, {6'h00, v, 16'h0000}, 2);
        waitDac(v);
    endtask
    // oldest note against present outputs
    always @(probe) check({stageEnable, pwmSelect, dacCode}, expQ.pop_front());
    // ramp steps and switch overlap
    always @(posedge clk) begin
        if (watchRamp && (dacCode > prevDac + 10'h001 || prevDac > dacCode + 10'h001))
            check({2'h0, dacCode}, {2'h0, prevDac});
        if (highSideOn && lowSideOn) check(12'h001, 12'h000);
        prevDac <= dacCode;
        senseAbove <= loopSense ? highSideOn : 1'($urandom);
    end
    initial begin
        repeat (98000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h3038EF8F));
        {rst_n, overtempIn, coilShortIn, coilOpenIn, senseAbove, watchRamp, loopSense} = 7'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        sp = 10'($urandom_range(6, 2));
        watchRamp <= 1'b1;
        u_host.xfer(8'h04, {6'h00, sp, 16'h00FF}, 4);
        waitDac(sp);
        watchRamp <= 1'b0;
        note({2'b10, sp});
        loopSense <= 1'b1;
        u_host.xfer(8'h02, 32'h0601_0000, 2);
        repeat (10) @(posedge clk);
        note({2'b11, sp});
        @(posedge highSideOn);
        t0 = $time;
        @(posedge highSideOn);
        check(12'(($time - t0) / 10), 12'h019);
        loopSense <= 1'b0;
        setSp(10'h000);
        note(12'h400);
        setSp(sp);
        for (int i = 0; i < 3; i++) begin
            {overtempIn, coilShortIn, coilOpenIn} <= 3'(3'b100 >> i);
            waitDac(10'h000);
            note(12'h400);
            {overtempIn, coilShortIn, coilOpenIn} <= 3'h0;
            setSp(sp);
        end
        u_host.xfer(8'h02, 32'h0100_0000, 1);
        waitDac(10'h000);
        note(12'h000);
        u_host.xfer(8'h03, {8'h01, 6'h00, sp, 8'h00}, 3);
        repeat (20) @(posedge clk);
        u_host.holdLow(500);
        waitDac(10'h000);
        note(12'h000);
        check(12'(u_host.nack), 12'h000);
        print_verdict();
    end
endmodule
`default_nettype wire
